// *** hw/vpmx_pkg.sv ***
package vpmx_pkg;
    localparam logic [7:0] VPMX_OFS_VIDEO_CTRL  = 8'h84;
    localparam logic [7:0] VPMX_OFS_EE_STATUS   = 8'h85;
    localparam logic [7:0] VPMX_OFS_PIN0_CTRL   = 8'h88;
    localparam logic [7:0] VPMX_RST_VIDEO_CTRL  = 8'h00;
    localparam logic [7:0] VPMX_RST_PIN0_CTRL   = 8'h80;
    localparam int         VPMX_BIT_OUT_EN      = 7;
    localparam int         VPMX_BIT_SRC_SEL     = 6;
    localparam int         VPMX_BIT_SOCK1_VID   = 1;
    localparam int         VPMX_BIT_SOCK0_VID   = 0;
    localparam int         VPMX_BIT_EE_PRESENT  = 2;
    localparam int         VPMX_BIT_EE_ERROR    = 1;
    localparam int         VPMX_BIT_EE_BUSY     = 0;
    localparam int         VPMX_BIT_PIN0_DELTA  = 3;
    localparam int         VPMX_BIT_PIN0_DOUT   = 1;
    localparam logic [7:0] VPMX_VIDEO_WMASK     = 8'hc3;
    localparam logic [7:0] VPMX_PIN0_WMASK      = 8'hd2;
    localparam int         VPMX_SYNC_STAGES     = 3;
    // cycles after reset before pin changes count
    localparam logic [2:0] VPMX_PIN_SETTLE      = 3'(VPMX_SYNC_STAGES + 2);

    typedef enum logic [1:0] {
        VPMX_ROLE_ACT_LED,
        VPMX_ROLE_VID_STAT,
        VPMX_ROLE_GP_IN,
        VPMX_ROLE_GP_OUT
    } vpmx_role_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } vpmx_cfg_req_t;

    typedef struct packed {
        logic       busy;
        logic       error;
        logic       present;
    } vpmx_ee_stat_t;
endpackage

// *** hw/vpmx_regs.sv ***
// Notes on behaviour
// - video out bit 7 low keeps the video output pins undriven, high drives them; resets low.
// - bit 6 picks card 0 (0) or card 1 (1) video for the output, only if that card's video mode is on.
// - bit 1 puts socket 1 in video mode, taking its video in and turning off shared-pin drivers.
// - bit 0 puts socket 0 in video mode, taking its video in and turning off shared-pin drivers.
// - video control bits 5 to 2 read zero and ignore writes.
// - video control sits at 84h for both functions, resets to 00h, and is meant for function 0.
// - loader status at 85h is read-only except bit 1, which a written one clears, with bits 7 to 3 reading zero.
// - status bit 2 shows whether a serial eeprom was detected, reset value follows detection.
// - status bit 1 sets on an eeprom data error and stays until software writes a one to it.
// - status bit 0 reads one while the loader fetches the subsystem id, zero when idle.
// - pin 0 control sits at 88h for both functions, resets to 80h so the pin is an input.
// - pin 0 can also be the socket 0 activity led, video status or a general output.
// - pin 0 role bits 7-6: 00 activity led, 01 video status, 10 input, 11 output.
`timescale 1ns/1ps
`default_nettype none
module vpmx_regs
    import vpmx_pkg::*;
#(
    parameter int VW = 19
) (
    input  wire logic          clk,
    input  wire logic          srst,
    input  wire logic          ce,
    input  wire vpmx_cfg_req_t cfg_req,
    input  wire logic          cfg_func,
    output logic      [7:0]    cfg_rdata,
    input  wire vpmx_ee_stat_t ee_stat,
    input  wire logic          ee_error_pulse,
    input  wire logic          socket0_activity,
    input  wire logic [VW-1:0] card0_video,
    input  wire logic [VW-1:0] card1_video,
    output logic      [VW-1:0] video_out,
    output logic               video_out_oe,
    output logic               card_video_oe_n,
    input  wire logic          aux_pin0_in,
    output logic               aux_pin0_out,
    output logic               aux_pin0_oe
);
    logic [7:0] vctl_d, vctl_q;
    logic [7:0] pctl_d, pctl_q;
    logic       err_d, err_q;
    logic [7:0] rdata_d, rdata_q;
    logic       pout_d, pout_q;
    logic       poe_d, poe_q;
    logic       pin_prev_d, pin_prev_q;
    logic [2:0] settle_d, settle_q;
    logic [1:0] sync_out;
    logic       pin_in, ee_present_s;
    vpmx_role_t role;

    vpmx_sync #(
        .W    (2)
    ) u_sync (
        .clk  (clk),
        .srst (srst),
        .ce   (ce),
        .din  ({aux_pin0_in, ee_stat.present}),
        .dout (sync_out)
    );
    assign pin_in       = sync_out[1];
    assign ee_present_s = sync_out[0];
    assign role         = vpmx_role_t'(pctl_q[7:6]);

    vpmx_video_mux #(
        .VW              (VW)
    ) u_mux (
        .clk             (clk),
        .srst            (srst),
        .ce              (ce),
        .ctrl            (vctl_q),
        .card0_video     (card0_video),
        .card1_video     (card1_video),
        .video_out       (video_out),
        .video_out_oe    (video_out_oe),
        .card_video_oe_n (card_video_oe_n)
    );

    // register writes, both functions decode the same offsets
    always_comb begin
        vctl_d     = vctl_q;
        pctl_d     = pctl_q;
        err_d      = err_q;
        pin_prev_d = pin_in;
        settle_d   = settle_q;
        if (settle_q != VPMX_PIN_SETTLE) begin
            settle_d = settle_q + 3'h1;
        end
        if (cfg_req.wr) begin
            if (cfg_req.addr == VPMX_OFS_VIDEO_CTRL) begin
                vctl_d = cfg_req.wdata & VPMX_VIDEO_WMASK;
            end else if (cfg_req.addr == VPMX_OFS_EE_STATUS) begin
                if (cfg_req.wdata[VPMX_BIT_EE_ERROR]) begin
                    err_d = 1'b0;
                end
            end else if (cfg_req.addr == VPMX_OFS_PIN0_CTRL) begin
                pctl_d = (pctl_q & ~VPMX_PIN0_WMASK)
                       | (cfg_req.wdata & VPMX_PIN0_WMASK);
                if (cfg_req.wdata[VPMX_BIT_PIN0_DELTA]) begin
                    pctl_d[VPMX_BIT_PIN0_DELTA] = 1'b0;
                end
            end
        end
        // input change flag, set wins over clear, quiet while sync settles
        if (settle_q == VPMX_PIN_SETTLE && role == VPMX_ROLE_GP_IN
                && pin_in != pin_prev_q) begin
            pctl_d[VPMX_BIT_PIN0_DELTA] = 1'b1;
        end
        pctl_d[0] = pin_in;
        if (ee_error_pulse) begin
            err_d = 1'b1;
        end
    end

    // read data and pin 0 drive
    always_comb begin
        rdata_d = 8'h00;
        if (cfg_req.rd) begin
            if (cfg_req.addr == VPMX_OFS_VIDEO_CTRL) begin
                rdata_d = vctl_q & VPMX_VIDEO_WMASK;
            end else if (cfg_req.addr == VPMX_OFS_EE_STATUS) begin
                rdata_d = {5'h00, ee_present_s, err_q, ee_stat.busy};
            end else if (cfg_req.addr == VPMX_OFS_PIN0_CTRL) begin
                rdata_d = pctl_q;
            end
        end
        pout_d = 1'b0;
        poe_d  = 1'b1;
        case (role)
            VPMX_ROLE_ACT_LED:  pout_d = socket0_activity;
            VPMX_ROLE_VID_STAT: pout_d = vctl_q[VPMX_BIT_OUT_EN];
            VPMX_ROLE_GP_IN:    poe_d  = 1'b0;
            VPMX_ROLE_GP_OUT:   pout_d = pctl_q[VPMX_BIT_PIN0_DOUT];
            default:            poe_d  = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            vctl_q     <= VPMX_RST_VIDEO_CTRL;
            pctl_q     <= VPMX_RST_PIN0_CTRL;
            err_q      <= 1'b0;
            rdata_q    <= 8'h00;
            pout_q     <= 1'b0;
            poe_q      <= 1'b0;
            pin_prev_q <= 1'b0;
            settle_q   <= 3'h0;
        end else if (ce) begin
            vctl_q     <= vctl_d;
            pctl_q     <= pctl_d;
            err_q      <= err_d;
            rdata_q    <= rdata_d;
            pout_q     <= pout_d;
            poe_q      <= poe_d;
            pin_prev_q <= pin_prev_d;
            settle_q   <= settle_d;
        end
    end

    assign cfg_rdata    = rdata_q;
    assign aux_pin0_out = pout_q;
    assign aux_pin0_oe  = poe_q;
endmodule
`default_nettype wire

// *** hw/vpmx_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module vpmx_sync
    import vpmx_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic         ce,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] s1_q, s2_q, s3_q, s1_d, s2_d, s3_d, out_d, out_q;

    always_comb begin
        s1_d  = din;
        s2_d  = s1_q;
        s3_d  = s2_q;
        out_d = out_q;
        for (int i = 0; i < W; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                out_d[i] = s3_q[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            out_q <= '0;
        end else if (ce) begin
            s1_q  <= s1_d;
            s2_q  <= s2_d;
            s3_q  <= s3_d;
            out_q <= out_d;
        end
    end

    assign dout = out_q;
endmodule
`default_nettype wire

// *** hw/vpmx_video_mux.sv ***
`timescale 1ns/1ps
`default_nettype none
module vpmx_video_mux
    import vpmx_pkg::*;
#(
    parameter int VW = 19
) (
    input  wire logic          clk,
    input  wire logic          srst,
    input  wire logic          ce,
    input  wire logic [7:0]    ctrl,
    input  wire logic [VW-1:0] card0_video,
    input  wire logic [VW-1:0] card1_video,
    output logic      [VW-1:0] video_out,
    output logic               video_out_oe,
    output logic               card_video_oe_n
);
    logic [VW-1:0] dat_d, dat_q;
    logic          oe_d, oe_q, cdis_d, cdis_q;

    always_comb begin
        dat_d = '0;
        if (ctrl[VPMX_BIT_SRC_SEL]) begin
            if (ctrl[VPMX_BIT_SOCK1_VID]) begin
                dat_d = card1_video;
            end
        end else if (ctrl[VPMX_BIT_SOCK0_VID]) begin
            dat_d = card0_video;
        end
        oe_d   = ctrl[VPMX_BIT_OUT_EN];
        cdis_d = ctrl[VPMX_BIT_SOCK0_VID] | ctrl[VPMX_BIT_SOCK1_VID];
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            dat_q  <= '0;
            oe_q   <= 1'b0;
            cdis_q <= 1'b0;
        end else if (ce) begin
            dat_q  <= dat_d;
            oe_q   <= oe_d;
            cdis_q <= cdis_d;
        end
    end

    assign video_out       = dat_q;
    assign video_out_oe    = oe_q;
    assign card_video_oe_n = cdis_q;
endmodule
`default_nettype wire

// *** tb/video_port_mux_and_status_regs_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module video_port_mux_and_status_regs_bench;
    import vpmx_pkg::*;
    logic          clk = 1'b0, srst = 1'b1, ce = 1'b1, cfg_func;
    logic          ee_error_pulse = 1'b0, socket0_activity = 1'b1;
    logic          aux_pin0_in = 1'b0, aux_pin0_out, aux_pin0_oe;
    logic          video_out_oe, card_video_oe_n;
    logic [7:0]    cfg_rdata;
    logic [18:0]   card0_video = 19'h5a5a5, card1_video = 19'h2c3c1, video_out;
    vpmx_cfg_req_t cfg_req;
    vpmx_ee_stat_t ee_stat = 3'h1;
    int            n_errors = 0, num_checks = 0;
    always #12.5 clk = ~clk;
    vpmx_regs #(.VW(19)) u_vpmx_regs (.clk, .srst, .ce, .cfg_req, .cfg_func,
        .cfg_rdata, .ee_stat, .ee_error_pulse, .socket0_activity, .card0_video,
        .card1_video, .video_out, .video_out_oe, .card_video_oe_n,
        .aux_pin0_in, .aux_pin0_out, .aux_pin0_oe);
    vpmx_host u_vpmx_host (.clk, .cfg_rdata, .cfg_req, .cfg_func);
    task automatic check(input string n, input logic [31:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic rchk(input logic [7:0] a, m, e);
        logic [7:0] d;
        u_vpmx_host.read(a, d);
        check($sformatf("reg %h", a), 32'(d & m), 32'(e));
    endtask
    task automatic wr(input logic [7:0] a, d);
        u_vpmx_host.write(a, d);
        repeat (2) @(negedge clk);
    endtask
    task automatic t_reset;
        check("oe", 32'(video_out_oe), 32'h0);
        check("pin oe", 32'(aux_pin0_oe), 32'h0);
        rchk(VPMX_OFS_VIDEO_CTRL, 8'hff, VPMX_RST_VIDEO_CTRL);
        rchk(VPMX_OFS_PIN0_CTRL, 8'hf6, VPMX_RST_PIN0_CTRL);
        rchk(VPMX_OFS_EE_STATUS, 8'hff, 8'h04);
        rchk(8'h86, 8'hff, 8'h00);
    endtask
    task automatic t_video;
        wr(VPMX_OFS_VIDEO_CTRL, 8'hff);
        rchk(VPMX_OFS_VIDEO_CTRL, 8'hff, 8'hc3);
        check("oe", 32'(video_out_oe), 32'h1);
        check("oe_n", 32'(card_video_oe_n), 32'h1);
        check("vid1", 32'(video_out), 32'(card1_video));
        wr(VPMX_OFS_VIDEO_CTRL, 8'h81);
        check("vid0", 32'(video_out), 32'(card0_video));
        wr(VPMX_OFS_VIDEO_CTRL, 8'h42);
        check("vid1b", 32'(video_out), 32'(card1_video));
        check("oe off", 32'(video_out_oe), 32'h0);
        wr(VPMX_OFS_VIDEO_CTRL, 8'h02);
        check("sel0 off", 32'(video_out), 32'h0);
        wr(VPMX_OFS_VIDEO_CTRL, 8'h41);
        check("sel1 off", 32'(video_out), 32'h0);
        wr(VPMX_OFS_VIDEO_CTRL, 8'h40);
        check("none", 32'(video_out), 32'h0);
        check("oe_n", 32'(card_video_oe_n), 32'h0);
    endtask
    task automatic t_status;
        @(posedge clk) ee_error_pulse <= 1'b1;
        @(posedge clk) ee_error_pulse <= 1'b0;
        rchk(VPMX_OFS_EE_STATUS, 8'h02, 8'h02);
        wr(VPMX_OFS_EE_STATUS, 8'hfd);
        rchk(VPMX_OFS_EE_STATUS, 8'hff, 8'h06);
        wr(VPMX_OFS_EE_STATUS, 8'h02);
        rchk(VPMX_OFS_EE_STATUS, 8'hff, 8'h04);
        @(posedge clk) ee_stat.busy <= 1'b1;
        rchk(VPMX_OFS_EE_STATUS, 8'h01, 8'h01);
        @(posedge clk) ee_stat.busy <= 1'b0;
        rchk(VPMX_OFS_EE_STATUS, 8'h01, 8'h00);
        @(posedge clk) ee_stat.present <= 1'b0;
        repeat (5) @(posedge clk);
        rchk(VPMX_OFS_EE_STATUS, 8'hff, 8'h00);
    endtask
    task automatic t_pin0;
        for (int r = 0; r < 4; r++) begin
            wr(VPMX_OFS_PIN0_CTRL, {2'(r), 6'h27});
            rchk(VPMX_OFS_PIN0_CTRL, 8'he6, {2'(r), 6'h02});
            check("pin oe", 32'(aux_pin0_oe), 32'(r != 2));
            if (r != 2) begin
                check("pin out", 32'(aux_pin0_out), 32'(r != 1));
            end
        end
        @(posedge clk) aux_pin0_in <= 1'b1;
        repeat (4) @(posedge clk);
        rchk(VPMX_OFS_PIN0_CTRL, 8'h01, 8'h01);
    endtask
    task automatic t_freeze;
        @(posedge clk) ce <= 1'b0;
        u_vpmx_host.write(VPMX_OFS_VIDEO_CTRL, 8'h81);
        @(posedge clk) ce <= 1'b1;
        repeat (2) @(negedge clk);
        check("frozen oe", 32'(video_out_oe), 32'h0);
        rchk(VPMX_OFS_VIDEO_CTRL, 8'hff, 8'h40);
    endtask
    task automatic t_rerst;
        @(posedge clk) srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        repeat (8) @(negedge clk);
        check("rst pin oe", 32'(aux_pin0_oe), 32'h0);
        rchk(VPMX_OFS_VIDEO_CTRL, 8'hff, VPMX_RST_VIDEO_CTRL);
        rchk(VPMX_OFS_PIN0_CTRL, 8'hfe, VPMX_RST_PIN0_CTRL);
    endtask
    task automatic complete_run;
        if (n_errors == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        repeat (6) @(negedge clk);
        t_reset;
        t_video;
        t_status;
        t_pin0;
        t_freeze;
        t_rerst;
        complete_run;
    end
    initial begin
        repeat (3000) @(posedge clk);
        n_errors++;
        complete_run;
    end
endmodule
`default_nettype wire

// *** tb/vpmx_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module vpmx_host
    import vpmx_pkg::*;
(
    input  wire logic    clk,
    input  wire logic [7:0] cfg_rdata,
    output vpmx_cfg_req_t cfg_req,
    output logic          cfg_func
);
    initial begin
        cfg_req  = '0;
        cfg_func = 1'b0; // function 0 only
    end
    task automatic write(input logic [7:0] a, d);
        @(posedge clk);
        cfg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        cfg_req <= '0;
    endtask
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        cfg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        cfg_req <= '0;
        @(negedge clk);
        d = cfg_rdata;
    endtask
endmodule
`default_nettype wire

// *** tb/vpmx_regs_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module vpmx_regs_asserts
    import vpmx_pkg::*;
#(
    parameter int VW = 19
) (
    input wire logic          clk,
    input wire logic          srst,
    input wire logic          ce,
    input wire vpmx_cfg_req_t cfg_req,
    input wire logic [7:0]    cfg_rdata,
    input wire logic [VW-1:0] card0_video,
    input wire logic [VW-1:0] card1_video,
    input wire logic [VW-1:0] video_out,
    input wire logic          video_out_oe,
    input wire logic          card_video_oe_n,
    input wire logic          aux_pin0_oe
);
    logic [7:0] vc_q, vc_d;
    logic [1:0] role_q, role_d;
    always_comb begin
        vc_d   = vc_q;
        role_d = role_q;
        if (ce && cfg_req.wr && cfg_req.addr == VPMX_OFS_VIDEO_CTRL) begin
            vc_d = cfg_req.wdata & VPMX_VIDEO_WMASK;
        end
        if (ce && cfg_req.wr && cfg_req.addr == VPMX_OFS_PIN0_CTRL) begin
            role_d = cfg_req.wdata[7:6];
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            vc_q   <= VPMX_RST_VIDEO_CTRL;
            role_q <= VPMX_RST_PIN0_CTRL[7:6];
        end else begin
            vc_q   <= vc_d;
            role_q <= role_d;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    a_out_drive: assert property (
        ce |=> video_out_oe == $past(vc_q[7]))
        else $error("output enable wrong");
    a_shared_off: assert property (
        ce |=> card_video_oe_n == $past(|vc_q[1:0]))
        else $error("shared driver state wrong");
    a_pick_card0: assert property (
        ce && vc_q[0] && !vc_q[6] |=> video_out == $past(card0_video))
        else $error("card 0 video not routed");
    a_pick_card1: assert property (
        ce && vc_q[1] && vc_q[6] |=> video_out == $past(card1_video))
        else $error("card 1 video not routed");
    a_no_video: assert property (
        ce && vc_q[1:0] == 2'h0 |=> video_out == '0)
        else $error("video leaks with no mode");
    a_read_ctrl: assert property (
        ce && cfg_req.rd && cfg_req.addr == VPMX_OFS_VIDEO_CTRL
        |-> ##1 cfg_rdata == $past(vc_q))
        else $error("control readback wrong");
    a_read_idle: assert property (
        ce && !cfg_req.rd |=> cfg_rdata == 8'h00)
        else $error("read data not idle");
    a_pin_drive: assert property (
        ce |=> aux_pin0_oe == ($past(role_q) != 2'h2))
        else $error("pin 0 drive wrong");
    cover property (vc_q[0] && !vc_q[6]);
    cover property (vc_q[1] && vc_q[6]);
    cover property (role_q == 2'h3);
endmodule
bind vpmx_regs vpmx_regs_asserts #(.VW(VW)) u_vpmx_regs_asserts (.clk, .srst,
    .ce, .cfg_req, .cfg_rdata, .card0_video, .card1_video, .video_out,
    .video_out_oe, .card_video_oe_n, .aux_pin0_oe);
`default_nettype wire
